/* File: design/awp_attr.sv */
`include "awp_regs.svh"
`timescale 1ns/1ps
`default_nettype none
// --------------------------------------------------
// request attribute encoder
// --------------------------------------------------
module awp_attr (
  // request source
  input  wire logic       from_coherence,
  input  wire logic [1:0] coh_burst,
  input  wire logic       early_resp,
  input  wire logic       zero_line,
  input  wire logic       clean_evict,
  input  wire logic       l1_evict,
  input  wire logic [3:0] mem_type,
  input  wire logic       shared,
  input  wire logic [1:0] outer_policy,
  // encoded fields
  output logic [1:0]      burst,
  output logic [8:0]      sideband,
  output logic [3:0]      cache_type
);
  // reserved 11 from the slave port falls back to incrementing
  wire logic coh_ok = (coh_burst != 2'h3);
  assign burst = (from_coherence && coh_ok) ? coh_burst : `AWP_BURST_INCR;
  assign sideband = {early_resp, zero_line, clean_evict, l1_evict, mem_type, shared};
  // bufferable from mem type, allocate bits from outer policy
  assign cache_type = {outer_policy, (mem_type[3:1] != 3'h0), mem_type[0]};
endmodule
`default_nettype wire

/* File: design/awp_pkg.sv */
package awp_pkg;
  typedef enum logic [1:0] {
    AWP_SZ_8  = 2'h0,
    AWP_SZ_16 = 2'h1,
    AWP_SZ_32 = 2'h2,
    AWP_SZ_64 = 2'h3
  } awp_size_t;
  typedef enum logic [1:0] {
    AWP_IDLE = 2'h0,
    AWP_BUSY = 2'h1,
    AWP_RESP = 2'h3
  } awp_state_t;
endpackage

/* File: design/awp_regs.svh */
`ifndef AWP_REGS_SVH
`define AWP_REGS_SVH
// burst type encodings
`define AWP_BURST_FIXED 2'h0
`define AWP_BURST_INCR  2'h1
`define AWP_BURST_WRAP  2'h2
// sideband field positions
`define AWP_SB_EARLY_RESP 8
`define AWP_SB_ZERO_LINE  7
`define AWP_SB_CLEAN_EVICT 6
`define AWP_SB_L1_EVICT   5
`define AWP_SB_MEM_HI     4
`define AWP_SB_MEM_LO     1
`define AWP_SB_SHARED     0
// widths
`define AWP_ID_W   6
`define AWP_DATA_W 64
`define AWP_STRB_W 8
`define AWP_SB_W   9
`endif

/* File: design/awp_top.sv */
// Overview of operation
// - core writes use incrementing burst, code 01
// - coherence port fixed or wrapping bursts pass through unchanged
// - reserved burst code never driven
// - size 00/01/10/11 means 8/16/32/64 bit beats
// - sideband bit 8 requests early write response
// - sideband bit 7 flags full line of zeros
// - bit 6 clean eviction, bit 5 level 1 eviction
// - bits 4:1 memory type and inner policy, bit 0 shared
// - 64-bit data with 8-bit byte strobe
// - all write ids are 6 bits
// - 4-bit length gives beats per burst minus one
// - cache type from memory type and outer policy
`include "awp_regs.svh"
`timescale 1ns/1ps
`default_nettype none
module awp_top
  import awp_pkg::*;
(
  // clock and reset
  input  wire logic                   CORE_CLK,
  input  wire logic                   RSTN,
  // request side
  input  wire logic                   REQ_VALID,
  output logic                        REQ_READY,
  input  wire logic                   REQ_FROM_COH,
  input  wire logic [1:0]             REQ_COH_BURST,
  input  wire logic [31:0]            REQ_ADDR,
  input  wire logic [`AWP_ID_W-1:0]   REQ_ID,
  input  wire logic [3:0]             REQ_LEN,
  input  wire awp_pkg::awp_size_t     REQ_SIZE,
  input  wire logic [1:0]             REQ_LOCK,
  input  wire logic [2:0]             REQ_PROT,
  input  wire logic                   REQ_EARLY_RESP,
  input  wire logic                   REQ_ZERO_LINE,
  input  wire logic                   REQ_CLEAN_EVICT,
  input  wire logic                   REQ_L1_EVICT,
  input  wire logic [3:0]             REQ_MEM_TYPE,
  input  wire logic                   REQ_SHARED,
  input  wire logic [1:0]             REQ_OUTER_POLICY,
  // beat side
  input  wire logic                   BEAT_VALID,
  output logic                        BEAT_READY,
  input  wire logic [`AWP_DATA_W-1:0] BEAT_DATA,
  input  wire logic [`AWP_STRB_W-1:0] BEAT_STRB,
  // response side
  output logic                        DONE_VALID,
  output logic [`AWP_ID_W-1:0]        DONE_ID,
  output logic [1:0]                  DONE_RESP,
  // write address channel
  output logic                        AWVALID,
  input  wire logic                   AWREADY,
  output logic [31:0]                 AWADDR,
  output logic [`AWP_ID_W-1:0]        AWID,
  output logic [3:0]                  AWLEN,
  output logic [1:0]                  AWSIZE,
  output logic [1:0]                  AWBURST,
  output logic [1:0]                  AWLOCK,
  output logic [2:0]                  AWPROT,
  output logic [3:0]                  AWCACHE,
  output logic [`AWP_SB_W-1:0]        AWUSER,
  // write data channel
  output logic                        WVALID,
  input  wire logic                   WREADY,
  output logic [`AWP_DATA_W-1:0]      WDATA,
  output logic [`AWP_STRB_W-1:0]      WSTRB,
  output logic [`AWP_ID_W-1:0]        WID,
  output logic                        WLAST,
  // write response channel
  input  wire logic                   BVALID,
  output logic                        BREADY,
  input  wire logic [`AWP_ID_W-1:0]   BID,
  input  wire logic [1:0]             BRESP
);
  import awp_pkg::*;

  // --------------------------------------------------
  // attribute encoding
  // --------------------------------------------------
  logic [1:0] enc_burst;
  logic [8:0] enc_sideband;
  logic [3:0] enc_cache;

  awp_attr u_attr (
    .from_coherence (REQ_FROM_COH),
    .coh_burst      (REQ_COH_BURST),
    .early_resp     (REQ_EARLY_RESP),
    .zero_line      (REQ_ZERO_LINE),
    .clean_evict    (REQ_CLEAN_EVICT),
    .l1_evict       (REQ_L1_EVICT),
    .mem_type       (REQ_MEM_TYPE),
    .shared         (REQ_SHARED),
    .outer_policy   (REQ_OUTER_POLICY),
    .burst          (enc_burst),
    .sideband       (enc_sideband),
    .cache_type     (enc_cache)
  );

  // --------------------------------------------------
  // burst sequencing
  // --------------------------------------------------
  awp_state_t state;
  awp_state_t next_state;
  logic [3:0] beats_left;
  logic       aw_done;
  logic       w_loaded;
  logic       w_done;

  wire logic req_take  = REQ_VALID && REQ_READY;
  wire logic aw_fire   = AWVALID && AWREADY;
  wire logic w_fire    = WVALID && WREADY;
  wire logic last_fire = w_fire && WLAST;
  wire logic beat_take = BEAT_VALID && BEAT_READY;
  wire logic aw_end    = aw_done || aw_fire;
  // last beat may leave before the address is accepted, so remember it
  wire logic w_end     = w_done || last_fire;
  // one burst outstanding; keeps beat/response order trivially matched
  wire logic burst_end = (state == AWP_BUSY) && aw_end && w_end;
  wire logic b_fire    = BVALID && BREADY;

  always_comb begin
    next_state = state;
    case (state)
      AWP_IDLE: begin
        if (req_take) next_state = AWP_BUSY;
      end
      AWP_BUSY: begin
        if (burst_end) next_state = AWP_RESP;
      end
      AWP_RESP: begin
        if (b_fire) next_state = AWP_IDLE;
      end
      default: next_state = AWP_IDLE;
    endcase
  end

  always_ff @(posedge CORE_CLK or negedge RSTN) begin
    if (!RSTN) state <= AWP_IDLE;
    else state <= next_state;
  end

  // --------------------------------------------------
  // address channel
  // --------------------------------------------------
  always_ff @(posedge CORE_CLK or negedge RSTN) begin
    if (!RSTN) begin
      AWVALID <= 1'b0;
      aw_done <= 1'b0;
      AWADDR  <= 32'h0;
      AWID    <= 6'h0;
      AWLEN   <= 4'h0;
      AWSIZE  <= 2'h0;
      AWBURST <= `AWP_BURST_INCR;
      AWLOCK  <= 2'h0;
      AWPROT  <= 3'h0;
      AWCACHE <= 4'h0;
      AWUSER  <= 9'h0;
    end else if (req_take) begin
      AWVALID <= 1'b1;
      aw_done <= 1'b0;
      AWADDR  <= REQ_ADDR;
      AWID    <= REQ_ID;
      AWLEN   <= REQ_LEN;
      AWSIZE  <= REQ_SIZE;
      AWBURST <= enc_burst;
      AWLOCK  <= REQ_LOCK;
      AWPROT  <= REQ_PROT;
      AWCACHE <= enc_cache;
      AWUSER  <= enc_sideband;
    end else if (aw_fire) begin
      AWVALID <= 1'b0;
      aw_done <= 1'b1;
    end
  end

  // --------------------------------------------------
  // data channel
  // --------------------------------------------------
  // beat register refills only once the held beat has gone out
  wire logic w_slot_free = !WVALID || w_fire;
  wire logic more_beats  = (state == AWP_BUSY) && !(last_fire);

  always_ff @(posedge CORE_CLK or negedge RSTN) begin
    if (!RSTN) begin
      WVALID     <= 1'b0;
      WDATA      <= 64'h0;
      WSTRB      <= 8'h0;
      WID        <= 6'h0;
      WLAST      <= 1'b0;
      beats_left <= 4'h0;
      w_loaded   <= 1'b0;
      w_done     <= 1'b0;
    end else begin
      if (req_take) begin
        beats_left <= REQ_LEN;
        WID        <= REQ_ID;
        w_loaded   <= 1'b0;
        w_done     <= 1'b0;
      end else if (beat_take) begin
        WVALID     <= 1'b1;
        WDATA      <= BEAT_DATA;
        WSTRB      <= BEAT_STRB;
        WLAST      <= (beats_left == 4'h0);
        w_loaded   <= (beats_left == 4'h0);
        beats_left <= beats_left - 4'h1;
      end else if (w_fire) begin
        WVALID <= 1'b0;
        WLAST  <= 1'b0;
        w_done <= w_done || WLAST;
      end
    end
  end

  // --------------------------------------------------
  // request, beat and response handshakes
  // --------------------------------------------------
  always_ff @(posedge CORE_CLK or negedge RSTN) begin
    if (!RSTN) begin
      REQ_READY  <= 1'b0;
      BEAT_READY <= 1'b0;
      BREADY     <= 1'b0;
      DONE_VALID <= 1'b0;
      DONE_ID    <= 6'h0;
      DONE_RESP  <= 2'h0;
    end else begin
      REQ_READY  <= (next_state == AWP_IDLE) && !req_take;
      BEAT_READY <= (next_state == AWP_BUSY) && !w_loaded && !(beat_take && beats_left == 4'h0)
                    && !(beat_take) && (w_slot_free || !WVALID) && more_beats && !req_take;
      BREADY     <= (next_state == AWP_RESP) && !b_fire;
      DONE_VALID <= b_fire;
      if (b_fire) begin
        DONE_ID   <= BID;
        DONE_RESP <= BRESP;
      end
    end
  end

  // --------------------------------------------------
  // checks
  // --------------------------------------------------
  default clocking cb @(posedge CORE_CLK); endclocking
  default disable iff (!RSTN);

  sequence aw_wait_s;
    AWVALID && !AWREADY;
  endsequence
  sequence aw_hold_s;
    AWVALID && $stable(AWADDR) && $stable(AWUSER) && $stable(AWBURST);
  endsequence

  aw_stable_a: assert property (aw_wait_s |=> aw_hold_s)
    else $error("address payload changed while waiting");
  w_stable_a: assert property (WVALID && !WREADY |=> WVALID && $stable(WDATA) && $stable(WLAST))
    else $error("data beat changed while waiting");
  burst_legal_a: assert property (AWVALID |-> AWBURST != 2'h3)
    else $error("reserved burst type driven");
  core_incr_a: assert property (req_take && !REQ_FROM_COH |=> AWBURST == `AWP_BURST_INCR)
    else $error("core burst not incrementing");
  coh_pass_a: assert property (req_take && REQ_FROM_COH && REQ_COH_BURST != 2'h3
                               |=> AWBURST == $past(REQ_COH_BURST))
    else $error("coherence burst type altered");
  user_map_a: assert property (req_take |=> AWUSER[8] == $past(REQ_EARLY_RESP)
                               && AWUSER[7] == $past(REQ_ZERO_LINE))
    else $error("sideband early or zero bit wrong");
  evict_map_a: assert property (req_take |=> AWUSER[6:5] == $past({REQ_CLEAN_EVICT, REQ_L1_EVICT})
                                && AWUSER[4:0] == $past({REQ_MEM_TYPE, REQ_SHARED}))
    else $error("sideband attribute bits wrong");
  len_size_a: assert property (req_take |=> AWLEN == $past(REQ_LEN) && AWSIZE == $past(REQ_SIZE))
    else $error("length or size not carried");
  resp_take_a: assert property (b_fire |=> DONE_VALID && DONE_ID == $past(BID))
    else $error("response not forwarded");
endmodule
`default_nettype wire

/* File: dv/awp_slave_model.sv */
`timescale 1ns/1ps
`default_nettype none
// ----------------------------------------
// far-side write slave, stalls on demand
// ----------------------------------------
module awp_slave_model (
  // clock and reset
  input  wire logic        CORE_CLK,
  input  wire logic        RSTN,
  // bench control
  input  wire logic        slow,
  input  wire logic [1:0]  resp_code,
  // address and data
  input  wire logic        AWVALID,
  output logic             AWREADY,
  input  wire logic [5:0]  AWID,
  input  wire logic [1:0]  AWBURST,
  input  wire logic [8:0]  AWUSER,
  input  wire logic        WVALID,
  output logic             WREADY,
  input  wire logic [63:0] WDATA,
  input  wire logic [7:0]  WSTRB,
  input  wire logic [5:0]  WID,
  input  wire logic        WLAST,
  // response
  output logic             BVALID,
  input  wire logic        BREADY,
  output logic [5:0]       BID,
  output logic [1:0]       BRESP
);
  logic        got_aw;
  logic        got_w;
  logic [4:0]  beats;
  logic [4:0]  n_beats;
  logic [5:0]  aw_id;
  logic [1:0]  aw_burst;
  logic [8:0]  aw_user;
  logic [63:0] w_data;
  logic [7:0]  w_strb;
  logic [5:0]  w_id;
  always @(posedge CORE_CLK or negedge RSTN) begin
    if (!RSTN) begin
      AWREADY <= 1'h0;
      WREADY <= 1'h0;
      BVALID <= 1'h0;
      BID <= 6'h0;
      BRESP <= 2'h0;
      got_aw <= 1'h0;
      got_w <= 1'h0;
      beats <= 5'h0;
    end else begin
      // slow: address held off until the last beat lands, data stalls every other cycle
      AWREADY <= slow ? got_w : 1'h1;
      WREADY <= slow ? ~WREADY : 1'h1;
      if (AWVALID && AWREADY) begin
        got_aw <= 1'h1;
        aw_id <= AWID;
        aw_burst <= AWBURST;
        aw_user <= AWUSER;
      end
      if (WVALID && WREADY) begin
        beats <= WLAST ? 5'h0 : beats + 5'h1;
        if (WLAST) begin
          got_w <= 1'h1;
          n_beats <= beats + 5'h1;
          w_data <= WDATA;
          w_strb <= WSTRB;
          w_id <= WID;
        end
      end
      if (got_aw && got_w && !BVALID) begin
        BVALID <= 1'h1;
        BID <= aw_id;
        BRESP <= resp_code;
        got_aw <= 1'h0;
        got_w <= 1'h0;
      end
      // released lines show the inverse, not a stale copy
      if (BVALID && BREADY) begin
        BVALID <= 1'h0;
        BID <= ~BID;
        BRESP <= ~BRESP;
      end
    end
  end
endmodule
`default_nettype wire

/* File: dv/axi_master0_write_port_test.sv */
`timescale 1ns/1ps
`default_nettype none
`define CHK(g, e) begin check_count++; if ((g) !== (e)) begin errors++; $display("wrong value at %0t: got %h expected %h", $time, g, e); end end
module axi_master0_write_port_test;
  import awp_pkg::*;
  logic        CORE_CLK, RSTN, REQ_VALID, REQ_READY, REQ_FROM_COH, BEAT_VALID, BEAT_READY, DONE_VALID;
  logic        REQ_EARLY_RESP, REQ_ZERO_LINE, REQ_CLEAN_EVICT, REQ_L1_EVICT, REQ_SHARED, slow;
  logic        AWVALID, AWREADY, WVALID, WREADY, WLAST, BVALID, BREADY;
  logic [1:0]  REQ_COH_BURST, REQ_LOCK, REQ_OUTER_POLICY, DONE_RESP, AWSIZE, AWBURST, AWLOCK, BRESP, resp_code;
  logic [31:0] REQ_ADDR, AWADDR;
  logic [5:0]  REQ_ID, DONE_ID, AWID, WID, BID;
  logic [3:0]  REQ_LEN, REQ_MEM_TYPE, AWLEN, AWCACHE;
  logic [2:0]  REQ_PROT, AWPROT;
  logic [63:0] BEAT_DATA, WDATA;
  logic [7:0]  BEAT_STRB, WSTRB;
  logic [8:0]  AWUSER;
  awp_size_t   REQ_SIZE;
  int          errors, check_count;
  awp_top         i_awp_top (.*);
  awp_slave_model i_awp_slave_model (.*);
  always #4 CORE_CLK = ~CORE_CLK;
  // ----------------------------------------
  // shared write transfer
  // ----------------------------------------
  task automatic run_write(input logic coh, input logic [1:0] cb, input logic [3:0] len,
                           input awp_size_t sz, input logic [8:0] ub, input logic [1:0] op);
    @(negedge CORE_CLK);
    REQ_VALID = 1'h1;
    REQ_FROM_COH = coh;
    REQ_COH_BURST = cb;
    REQ_LEN = len;
    REQ_SIZE = sz;
    {REQ_EARLY_RESP, REQ_ZERO_LINE, REQ_CLEAN_EVICT, REQ_L1_EVICT, REQ_MEM_TYPE, REQ_SHARED} = ub;
    REQ_OUTER_POLICY = op;
    REQ_LOCK = op;
    REQ_PROT = ub[2:0];
    REQ_ID = ub[5:0] ^ 6'h2a;
    REQ_ADDR = {23'h0, ub};
    do @(posedge CORE_CLK); while (REQ_READY !== 1'h1);
    @(negedge CORE_CLK);
    REQ_VALID = 1'h0;
    for (int i = 0; i <= len; i++) begin
      BEAT_VALID = 1'h1;
      BEAT_DATA = 64'h0123_4567_89ab_cdef ^ 64'(i);
      BEAT_STRB = 8'hff >> 3'(i);
      do @(posedge CORE_CLK); while (BEAT_READY !== 1'h1);
      @(negedge CORE_CLK);
    end
    BEAT_VALID = 1'h0;
    for (int n = 0; n < 300 && DONE_VALID !== 1'h1; n++) @(negedge CORE_CLK);
    `CHK(DONE_VALID, 1'h1)
    `CHK(DONE_ID, ub[5:0] ^ 6'h2a)
    `CHK(i_awp_slave_model.w_id, ub[5:0] ^ 6'h2a)
    `CHK(i_awp_slave_model.aw_id, ub[5:0] ^ 6'h2a)
    `CHK(AWID, ub[5:0] ^ 6'h2a)
    `CHK(DONE_RESP, resp_code)
    `CHK(i_awp_slave_model.n_beats, 5'(len) + 5'h1)
    `CHK(AWLEN, len)
    `CHK(AWSIZE, 2'(sz))
    `CHK(i_awp_slave_model.w_data, 64'h0123_4567_89ab_cdef ^ 64'(len))
    `CHK(i_awp_slave_model.w_strb, 8'hff >> 3'(len))
    `CHK(AWCACHE, {op, |ub[4:2], ub[1]})
    `CHK(AWADDR, {23'h0, ub})
    `CHK(AWLOCK, op)
    `CHK(AWPROT, ub[2:0])
  endtask
  // ----------------------------------------
  // scenarios
  // ----------------------------------------
  task automatic t_core_burst();
    // coherence burst code must be ignored for core writes
    run_write(1'h0, 2'h2, 4'h0, AWP_SZ_64, 9'h1a5, 2'h2);
    `CHK(i_awp_slave_model.aw_burst, 2'h1)
    run_write(1'h0, 2'h0, 4'h1, AWP_SZ_32, 9'h05a, 2'h1);
    `CHK(i_awp_slave_model.aw_burst, 2'h1)
  endtask
  task automatic t_coh_burst();
    logic [1:0] exp[3] = '{2'h0, 2'h2, 2'h1};
    logic [1:0] cbs[3] = '{2'h0, 2'h2, 2'h3};
    for (int k = 0; k < 3; k++) begin
      run_write(1'h1, cbs[k], 4'h2, AWP_SZ_64, 9'h011, 2'h3);
      `CHK(i_awp_slave_model.aw_burst, exp[k])
      `CHK(i_awp_slave_model.aw_burst !== 2'h3, 1'h1)
    end
  endtask
  task automatic t_sideband();
    logic [8:0] ub;
    for (int k = 0; k < 9; k++) begin
      ub = 9'h1 << k;
      resp_code = 2'(k);
      run_write(1'h0, 2'h0, 4'h0, AWP_SZ_8, ub, 2'(k));
      `CHK(i_awp_slave_model.aw_user[8], ub[8])
      `CHK(i_awp_slave_model.aw_user[7], ub[7])
      `CHK(i_awp_slave_model.aw_user[6:5], ub[6:5])
      `CHK(i_awp_slave_model.aw_user[4:0], ub[4:0])
    end
    resp_code = 2'h0;
  endtask
  task automatic t_sizes_slow();
    // slow slave: last beat goes before the address, longest burst on the last pass
    slow = 1'h1;
    for (int s = 0; s < 4; s++) run_write(1'h0, 2'h0, (s == 3) ? 4'hf : 4'(s), awp_size_t'(s), 9'h0f3, 2'h0);
    slow = 1'h0;
  endtask
  task automatic final_report();
    $display("checks %0d, errors %0d", check_count, errors);
    if (errors == 0 && check_count > 0) $display("TEST PASSED");
    else $display("TEST FAILED");
    $finish;
  endtask
  initial begin
    #400000;
    errors++;
    final_report();
  end
  initial begin
    {CORE_CLK, RSTN, REQ_VALID, REQ_FROM_COH, BEAT_VALID, slow, resp_code} = '0;
    {REQ_EARLY_RESP, REQ_ZERO_LINE, REQ_CLEAN_EVICT, REQ_L1_EVICT, REQ_SHARED} = '0;
    {REQ_COH_BURST, REQ_LOCK, REQ_OUTER_POLICY, REQ_ADDR, REQ_ID, REQ_LEN, REQ_MEM_TYPE, REQ_PROT} = '0;
    {BEAT_DATA, BEAT_STRB} = '0;
    REQ_SIZE = AWP_SZ_8;
    errors = 0;
    check_count = 0;
    repeat (3) @(negedge CORE_CLK);
    `CHK(AWBURST, 2'h1)
    `CHK(AWVALID, 1'h0)
    RSTN = 1'h1;
    t_core_burst();
    t_coh_burst();
    t_sideband();
    t_sizes_slow();
    final_report();
  end
endmodule
`default_nettype wire
